// File: src/usb_line_ctrl_pkg.sv
package usb_line_ctrl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 16;
    localparam int          NUM_ENGINES     = 2;
    localparam logic [15:0] PORT1_CTRL_ADDR = 16'hc08a;
    localparam logic [15:0] PORT2_CTRL_ADDR = 16'hc0aa;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    // Only the writable control bits are stored
    localparam logic [15:0] CTRL_WRITE_MASK = 16'h069d;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DP_STATUS_BIT    = 13;
    localparam int DM_STATUS_BIT    = 12;
    localparam int LOW_SPEED_BIT    = 10;
    localparam int HOST_MODE_BIT    = 9;
    localparam int RES_ENABLE_BIT   = 7;
    localparam int FORCE_HI_BIT     = 4;
    localparam int FORCE_LO_BIT     = 3;
    localparam int SUSPEND_BIT      = 2;
    localparam int FRAME_MARKER_BIT = 0;

    // ------------------------------------------------------------
    // Force field codes
    // ------------------------------------------------------------
    localparam logic [1:0] FORCE_NONE = 2'h0;
    localparam logic [1:0] FORCE_SE0  = 2'h1;
    localparam logic [1:0] FORCE_J    = 2'h2;
    localparam logic [1:0] FORCE_K    = 2'h3;

    // ------------------------------------------------------------
    // Line control carried to the transceiver of one engine
    // ------------------------------------------------------------
    typedef struct packed {
        logic pull_up_dp;
        logic pull_up_dm;
        logic pull_down;
        logic force_en;
        logic force_dp;
        logic force_dm;
        logic xcvr_off;
        logic frame_marker;
        logic host_mode;
        logic low_speed;
        logic port_active;
    } line_ctrl_t;

    localparam line_ctrl_t LINE_RESET = '0;

endpackage

// File: src/line_level_sync.sv
`timescale 1ns/1ps

module line_level_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    if (W < 1)
    begin : g_check
        $error("line_level_sync needs W of at least one");
    end

    always_comb
    begin
        next_meta = d_i;
        next_q    = meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta <= '0;
            q_o  <= '0;
        end
        else
        begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end

endmodule

// File: src/usb_port_line_control.sv
`timescale 1ns/1ps

// What this block does
// - Status bit 13 reads the live D+ level of the port.
// - Status bit 12 reads the live D- level of the port.
// - Bit 10 selects low speed when one, full speed when zero.
// - Bit 9 selects host operation when one, device operation when zero.
// - Device operation serves only the port chosen by the port-choice input.
// - Bit 7 gates resistors: host pulls both down, device one pull-up by speed.
// - Bits 4:3 force normal, SE0, J or K regardless of port choice.
// - Bit 2 powers down the transceiver of its own engine only; wakeup monitoring of lines continues.
// - Bit 0 enables frame markers on the active port in host operation only.
// - Register is read and written by both processor and external host port.
// - Two identical registers, one per engine, at c08a and c0aa.
module usb_port_line_control
    import usb_line_ctrl_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // Clock and reset
    input  wire logic                   CLOCK_I,
    input  wire logic                   RESET_N_I,
    // On-chip processor register port
    input  wire logic [AW-1:0]          CPU_ADDR_I,
    input  wire logic                   CPU_WR_I,
    input  wire logic                   CPU_RD_I,
    input  wire logic [DATA_W-1:0]      CPU_WDATA_I,
    output logic      [DATA_W-1:0]      CPU_RDATA_O,
    output logic                        CPU_RVALID_O,
    // External host interface register port
    input  wire logic [AW-1:0]          EXT_ADDR_I,
    input  wire logic                   EXT_WR_I,
    input  wire logic                   EXT_RD_I,
    input  wire logic [DATA_W-1:0]      EXT_WDATA_I,
    output logic      [DATA_W-1:0]      EXT_RDATA_O,
    output logic                        EXT_RVALID_O,
    // Port choice from each engine's byte-count register
    input  wire logic [NUM_ENGINES-1:0] PORT_SELECT_I,
    // Raw data line levels, one per engine
    input  wire logic [NUM_ENGINES-1:0] DP_I,
    input  wire logic [NUM_ENGINES-1:0] DM_I,
    // Transceiver controls, one per engine
    output logic      [NUM_ENGINES-1:0] PULL_UP_DP_O,
    output logic      [NUM_ENGINES-1:0] PULL_UP_DM_O,
    output logic      [NUM_ENGINES-1:0] PULL_DOWN_O,
    output logic      [NUM_ENGINES-1:0] FORCE_EN_O,
    output logic      [NUM_ENGINES-1:0] FORCE_DP_O,
    output logic      [NUM_ENGINES-1:0] FORCE_DM_O,
    output logic      [NUM_ENGINES-1:0] XCVR_OFF_O,
    output logic      [NUM_ENGINES-1:0] FRAME_MARKER_O,
    output logic      [NUM_ENGINES-1:0] HOST_MODE_O,
    output logic      [NUM_ENGINES-1:0] LOW_SPEED_O,
    output logic      [NUM_ENGINES-1:0] PORT_ACTIVE_O
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLOCK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    if (AW != ADDR_W)
    begin : g_check
        $error("usb_port_line_control needs a 16-bit address");
    end

    // ------------------------------------------------------------
    // Line level synchronisers
    // ------------------------------------------------------------
    logic [2*NUM_ENGINES-1:0] line_sync;
    logic [NUM_ENGINES-1:0]   dp_s;
    logic [NUM_ENGINES-1:0]   dm_s;

    line_level_sync #(
        .W (2*NUM_ENGINES)
    ) u_line_sync (
        .clk_i   (CLOCK_I),
        .rst_n_i (rst_n),
        .d_i     ({DM_I, DP_I}),
        .q_o     (line_sync)
    );

    assign dp_s = line_sync[NUM_ENGINES-1:0];
    assign dm_s = line_sync[2*NUM_ENGINES-1:NUM_ENGINES];

    // ------------------------------------------------------------
    // Control registers and line drive
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ctl        [NUM_ENGINES];
    logic [DATA_W-1:0] next_ctl   [NUM_ENGINES];
    logic [DATA_W-1:0] reg_value  [NUM_ENGINES];
    line_ctrl_t        line       [NUM_ENGINES];
    line_ctrl_t        next_line  [NUM_ENGINES];
    logic              cpu_hit    [NUM_ENGINES];
    logic              ext_hit    [NUM_ENGINES];

    for (genvar e = 0; e < NUM_ENGINES; e++)
    begin : g_engine
        localparam logic [15:0] MY_ADDR = (e == 0) ? PORT1_CTRL_ADDR : PORT2_CTRL_ADDR;

        assign cpu_hit[e] = (CPU_ADDR_I == MY_ADDR);
        assign ext_hit[e] = (EXT_ADDR_I == MY_ADDR);

        always_comb
        begin
            reg_value[e] = ctl[e];
            reg_value[e][DP_STATUS_BIT] = dp_s[e];
            reg_value[e][DM_STATUS_BIT] = dm_s[e];
        end

        // Processor wins a same-cycle write collision
        always_comb
        begin
            next_ctl[e] = ctl[e];
            if (CPU_WR_I && cpu_hit[e])
            begin
                next_ctl[e] = CPU_WDATA_I & CTRL_WRITE_MASK;
            end
            else if (EXT_WR_I && ext_hit[e])
            begin
                next_ctl[e] = EXT_WDATA_I & CTRL_WRITE_MASK;
            end
        end

        always_comb
        begin
            logic       host;
            logic       ls;
            logic       ren;
            logic [1:0] frc;
            host = ctl[e][HOST_MODE_BIT];
            ls   = ctl[e][LOW_SPEED_BIT];
            ren  = ctl[e][RES_ENABLE_BIT];
            frc  = ctl[e][FORCE_HI_BIT:FORCE_LO_BIT];
            next_line[e]              = LINE_RESET;
            next_line[e].host_mode    = host;
            next_line[e].low_speed    = ls;
            next_line[e].port_active  = host | ~PORT_SELECT_I[e];
            next_line[e].pull_down    = ren & host;
            next_line[e].pull_up_dp   = ren & ~host & ~ls;
            next_line[e].pull_up_dm   = ren & ~host & ls;
            next_line[e].xcvr_off     = ctl[e][SUSPEND_BIT];
            next_line[e].frame_marker = ctl[e][FRAME_MARKER_BIT] & host
                                        & (host | ~PORT_SELECT_I[e]);
            // J and K polarity follows the selected speed
            case (frc)
                FORCE_NONE:
                begin
                    next_line[e].force_en = 1'b0;
                end
                FORCE_SE0:
                begin
                    next_line[e].force_en = 1'b1;
                end
                FORCE_J:
                begin
                    next_line[e].force_en = 1'b1;
                    next_line[e].force_dp = ~ls;
                    next_line[e].force_dm = ls;
                end
                FORCE_K:
                begin
                    next_line[e].force_en = 1'b1;
                    next_line[e].force_dp = ls;
                    next_line[e].force_dm = ~ls;
                end
                default:
                begin
                    next_line[e].force_en = 1'b0;
                end
            endcase
        end

        always_ff @(posedge CLOCK_I or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ctl[e]  <= CTRL_RESET;
                line[e] <= LINE_RESET;
            end
            else
            begin
                ctl[e]  <= next_ctl[e];
                line[e] <= next_line[e];
            end
        end

        assign {PULL_UP_DP_O[e], PULL_UP_DM_O[e], PULL_DOWN_O[e], FORCE_EN_O[e],
                FORCE_DP_O[e], FORCE_DM_O[e], XCVR_OFF_O[e], FRAME_MARKER_O[e],
                HOST_MODE_O[e], LOW_SPEED_O[e], PORT_ACTIVE_O[e]} = line[e];
    end

    // ------------------------------------------------------------
    // Read ports
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_cpu_rdata;
    logic [DATA_W-1:0] next_ext_rdata;

    // Unmapped addresses read as zero
    always_comb
    begin
        next_cpu_rdata = CPU_RDATA_O;
        next_ext_rdata = EXT_RDATA_O;
        if (CPU_RD_I)
        begin
            next_cpu_rdata = cpu_hit[0] ? reg_value[0] :
                             cpu_hit[1] ? reg_value[1] : '0;
        end
        if (EXT_RD_I)
        begin
            next_ext_rdata = ext_hit[0] ? reg_value[0] :
                             ext_hit[1] ? reg_value[1] : '0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            CPU_RDATA_O  <= '0;
            EXT_RDATA_O  <= '0;
            CPU_RVALID_O <= 1'b0;
            EXT_RVALID_O <= 1'b0;
        end
        else
        begin
            CPU_RDATA_O  <= next_cpu_rdata;
            EXT_RDATA_O  <= next_ext_rdata;
            CPU_RVALID_O <= CPU_RD_I;
            EXT_RVALID_O <= EXT_RD_I;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!rst_n);

    dp_status_a: assert property ($past(rst_n, 2) |->
        reg_value[0][13] == $past(DP_I[0], 2))
        else $error("D+ status does not follow the line");
    dm_status_a: assert property ($past(rst_n, 2) |->
        reg_value[1][12] == $past(DM_I[1], 2))
        else $error("D- status does not follow the line");
    speed_sel_a: assert property (CPU_WR_I && cpu_hit[0] |->
        ##2 LOW_SPEED_O[0] == $past(CPU_WDATA_I[10], 2))
        else $error("Low speed output does not follow bit 10");
    host_sel_a: assert property (EXT_WR_I && ext_hit[1]
        && !(CPU_WR_I && cpu_hit[1]) |-> ##2 HOST_MODE_O[1] == $past(EXT_WDATA_I[9], 2))
        else $error("Host mode output does not follow bit 9");
    port_choice_a: assert property (!ctl[0][9] && PORT_SELECT_I[0] |=>
        !PORT_ACTIVE_O[0] && !FRAME_MARKER_O[0])
        else $error("Unchosen port active in device operation");
    res_off_a: assert property (!ctl[1][7] |=>
        !PULL_UP_DP_O[1] && !PULL_UP_DM_O[1] && !PULL_DOWN_O[1])
        else $error("Resistor on while disabled");
    dev_pullup_a: assert property (ctl[0][7] && !ctl[0][9] |=>
        PULL_UP_DM_O[0] == $past(ctl[0][10]) && PULL_UP_DP_O[0] != PULL_UP_DM_O[0]
        && !PULL_DOWN_O[0])
        else $error("Wrong device pull-up");
    force_se0_a: assert property (ctl[1][4:3] == FORCE_SE0 |=>
        FORCE_EN_O[1] && !FORCE_DP_O[1] && !FORCE_DM_O[1])
        else $error("SE0 not forced");
    force_k_a: assert property (ctl[0][4:3] == FORCE_K && !ctl[0][10] |=>
        FORCE_EN_O[0] && !FORCE_DP_O[0] && FORCE_DM_O[0])
        else $error("Full speed K not forced");
    suspend_a: assert property ($rose(ctl[0][2]) |=>
        XCVR_OFF_O[0] ##1 (XCVR_OFF_O[0] || !ctl[0][2]))
        else $error("Suspend does not power down");
    marker_a: assert property (FRAME_MARKER_O[1] |-> $past(ctl[1][0] && ctl[1][9]))
        else $error("Frame marker outside host operation");

    host_pull_c: cover property (ctl[0][7] && ctl[0][9] ##1 PULL_DOWN_O[0]);
    force_j_c: cover property (ctl[1][4:3] == FORCE_J ##1 FORCE_EN_O[1]);
    marker_c: cover property (FRAME_MARKER_O[0] && LOW_SPEED_O[0]);
    read_c: cover property (EXT_RD_I && ext_hit[1] ##1 EXT_RVALID_O);

endmodule

// File: bench/usb_cable_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Far end of the cable, one line pair per engine
// ------------------------------------------------------------
module usb_cable_model (
    // Clock
    input  wire logic       clk_i,
    // Far-end drive
    input  wire logic [1:0] drive_i,
    input  wire logic [1:0] dp_drv_i,
    input  wire logic [1:0] dm_drv_i,
    // Line controls from the block
    input  wire logic [1:0] pull_up_dp_i,
    input  wire logic [1:0] pull_up_dm_i,
    input  wire logic [1:0] pull_down_i,
    input  wire logic [1:0] force_en_i,
    input  wire logic [1:0] force_dp_i,
    input  wire logic [1:0] force_dm_i,
    // Wire levels
    output logic      [1:0] dp_o,
    output logic      [1:0] dm_o
);
    initial
    begin
        dp_o = 2'h0;
        dm_o = 2'h0;
    end

    // A floating line toggles so no stale level passes for a driven one
    always @(posedge clk_i)
    begin
        for (int e = 0; e < 2; e++)
        begin
            if (force_en_i[e])
            begin
                dp_o[e] <= force_dp_i[e];
                dm_o[e] <= force_dm_i[e];
            end
            else if (drive_i[e])
            begin
                dp_o[e] <= dp_drv_i[e];
                dm_o[e] <= dm_drv_i[e];
            end
            else
            begin
                dp_o[e] <= pull_up_dp_i[e] ? 1'b1 : (pull_down_i[e] ? 1'b0 : ~dp_o[e]);
                dm_o[e] <= pull_up_dm_i[e] ? 1'b1 : (pull_down_i[e] ? 1'b0 : ~dm_o[e]);
            end
        end
    end
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps

module testbench
    import usb_line_ctrl_pkg::*;
;
    logic        clk = 0, rst_n = 0, c_wr = 0, c_rd = 0, e_wr = 0, e_rd = 0, crv, erv;
    logic [15:0] c_addr = 0, c_wd = 0, e_addr = 0, e_wd = 0, crd, erd, got, d;
    logic [1:0]  psel = 0, drv = 0, dpd = 0, dmd = 0, dp, dm;
    logic [1:0]  pudp, pudm, pd, fen, fdp, fdm, xoff, fm, hm, ls, act;
    logic [15:0] ctl [2];
    int          error_cnt = 0, checks = 0, cyc = 0, e;
    bit          ext;

    usb_port_line_control usb_port_line_control_i (
        .CLOCK_I(clk), .RESET_N_I(rst_n),
        .CPU_ADDR_I(c_addr), .CPU_WR_I(c_wr), .CPU_RD_I(c_rd), .CPU_WDATA_I(c_wd),
        .CPU_RDATA_O(crd), .CPU_RVALID_O(crv),
        .EXT_ADDR_I(e_addr), .EXT_WR_I(e_wr), .EXT_RD_I(e_rd), .EXT_WDATA_I(e_wd),
        .EXT_RDATA_O(erd), .EXT_RVALID_O(erv), .PORT_SELECT_I(psel), .DP_I(dp), .DM_I(dm),
        .PULL_UP_DP_O(pudp), .PULL_UP_DM_O(pudm), .PULL_DOWN_O(pd), .FORCE_EN_O(fen),
        .FORCE_DP_O(fdp), .FORCE_DM_O(fdm), .XCVR_OFF_O(xoff), .FRAME_MARKER_O(fm),
        .HOST_MODE_O(hm), .LOW_SPEED_O(ls), .PORT_ACTIVE_O(act));

    usb_cable_model usb_cable_model_i (
        .clk_i(clk), .drive_i(drv), .dp_drv_i(dpd), .dm_drv_i(dmd), .pull_up_dp_i(pudp),
        .pull_up_dm_i(pudm), .pull_down_i(pd), .force_en_i(fen), .force_dp_i(fdp),
        .force_dm_i(fdm), .dp_o(dp), .dm_o(dm));

    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    always #50 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            error_cnt++;
            $display("ERROR %0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] a, input logic [15:0] b, input string m);
        checks++;
        if (a !== b)
        begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, m, a, b);
        end
    endtask

    // ------------------------------------------------------------
    // Reference model of the line outputs and read value
    // ------------------------------------------------------------
    function automatic logic [10:0] exp_lines(logic [15:0] c, logic ps);
        logic [1:0] f;
        logic       l, h, r, a, xp, xm;
        f  = c[4:3];
        l  = c[10];
        h  = c[9];
        r  = c[7];
        a  = h | !ps;
        xp = (f == FORCE_J) ? !l : ((f == FORCE_K) ? l : 1'b0);
        xm = (f == FORCE_J) ? l : ((f == FORCE_K) ? !l : 1'b0);
        return {r & !h & !l, r & !h & l, r & h, f != FORCE_NONE, xp, xm, c[2], c[0] & h & a,
                h, l, a};
    endfunction

    function automatic logic [15:0] rexp(int k);
        logic [10:0] x;
        logic [15:0] v;
        x     = exp_lines(ctl[k], psel[k]);
        v     = ctl[k];
        v[13] = x[7] ? x[6] : dpd[k];
        v[12] = x[7] ? x[5] : dmd[k];
        return v;
    endfunction

    task automatic chk_eng(int k);
        logic [10:0] g;
        g = {pudp[k], pudm[k], pd[k], fen[k], fdp[k], fdm[k], xoff[k], fm[k], hm[k], ls[k], act[k]};
        chk({5'h0, g}, {5'h0, exp_lines(ctl[k], psel[k])}, "line outputs");
    endtask

    // ------------------------------------------------------------
    // Register port cycles, one strobe cycle each
    // ------------------------------------------------------------
    task automatic wr(input bit x, input logic [15:0] a, input logic [15:0] v);
        if (x)
            {e_addr, e_wd, e_wr} = {a, v, 1'b1};
        else
            {c_addr, c_wd, c_wr} = {a, v, 1'b1};
        @(posedge clk);
        #1;
        c_wr = 0;
        e_wr = 0;
        // One idle edge so a following call never raises a strobe in this step
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input bit x, input logic [15:0] a, output logic [15:0] q);
        if (x)
            {e_addr, e_rd} = {a, 1'b1};
        else
            {c_addr, c_rd} = {a, 1'b1};
        @(posedge clk);
        #1;
        chk({15'h0, x ? erv : crv}, 16'h0001, "read valid");
        q = x ? erd : crd;
        c_rd = 0;
        e_rd = 0;
        @(posedge clk);
        #1;
        chk({15'h0, x ? erv : crv}, 16'h0000, "read valid stands one cycle");
    endtask

    function automatic logic [15:0] addr_of(int k);
        return k ? PORT2_CTRL_ADDR : PORT1_CTRL_ADDR;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(64598));
        ctl[0] = CTRL_RESET;
        ctl[1] = CTRL_RESET;
        repeat (3) @(posedge clk);
        #1 rst_n = 1;
        drv = 2'h3;
        dpd = 2'($urandom);
        dmd = 2'($urandom);
        repeat (5) @(posedge clk);
        #1;
        for (int k = 0; k < 2; k++)
        begin
            rd(1'(k), addr_of(k), got);
            chk(got, rexp(k), "reset value");
            chk_eng(k);
        end
        // Every speed, mode, resistor and force combination, bit 2 random, bit 0 random only in host mode
        for (int i = 0; i < 64; i++)
        begin
            e = $urandom_range(1, 0);
            ext = 1'($urandom_range(1, 0));
            d = 16'($urandom) & CTRL_WRITE_MASK;
            {d[4:3], d[7], d[9], d[10]} = 5'(i);
            if (!d[9])
                d[0] = 1'b0;
            psel = 2'($urandom);
            dpd = 2'($urandom);
            dmd = 2'($urandom);
            wr(ext, addr_of(e), d);
            ctl[e] = d;
            repeat (6) @(posedge clk);
            #1;
            chk_eng(0);
            chk_eng(1);
            rd(!ext, addr_of(e), got);
            chk(got, rexp(e), "read back");
        end
        // Unmapped places read zero and ignore writes
        rd(0, 16'hc08c, got);
        chk(got, 16'h0000, "unmapped read");
        wr(1, 16'hc08b, CTRL_WRITE_MASK);
        rd(1, PORT1_CTRL_ADDR, got);
        chk(got, rexp(0), "unmapped write");
        // Same-cycle writes from both ports, processor wins
        {c_addr, c_wd, c_wr} = {PORT2_CTRL_ADDR, 16'h0280, 1'b1};
        {e_addr, e_wd, e_wr} = {PORT2_CTRL_ADDR, 16'h0481, 1'b1};
        @(posedge clk);
        #1;
        c_wr = 0;
        e_wr = 0;
        ctl[1] = 16'h0280;
        repeat (6) @(posedge clk);
        #1;
        chk_eng(1);
        rd(0, PORT2_CTRL_ADDR, got);
        chk(got, rexp(1), "write collision");
        conclude();
    end
endmodule
